/* File: design/iltu_map.vh */
`ifndef ILTU_MAP_VH
`define ILTU_MAP_VH

// Instruction codes on cmdOp
`define ILTU_OP_HALF_LOAD 5'h00
`define ILTU_OP_HALF_STORE 5'h01
`define ILTU_OP_DBL_LOAD 5'h02
`define ILTU_OP_DBL_STORE 5'h03
`define ILTU_OP_WORD_COPY 5'h04
`define ILTU_OP_BYTE_COPY 5'h05
`define ILTU_OP_SYS_LOAD 5'h06
`define ILTU_OP_SYS_STORE 5'h07
`define ILTU_OP_BASE_IMM 5'h08
`define ILTU_OP_BASE_ADD 5'h09
`define ILTU_OP_REL_WLOAD 5'h0a
`define ILTU_OP_REL_DLOAD 5'h0b
`define ILTU_OP_REL_WSTORE 5'h0c
`define ILTU_OP_REL_DSTORE 5'h0d
`define ILTU_OP_JUMP_WORK 5'h0e
`define ILTU_OP_WORK_TO_BASE 5'h0f
`define ILTU_OP_CNT_TO_WORK 5'h10
`define ILTU_OP_CNT_TO_BASE 5'h11
`define ILTU_OP_BASE_TO_WORK 5'h12
`define ILTU_OP_BASE_TO_CNT 5'h13

// Half-register numbers
`define ILTU_HALF_W1_LO 4'h0
`define ILTU_HALF_W1_HI 4'h1
`define ILTU_HALF_W2_LO 4'h2
`define ILTU_HALF_W2_HI 4'h3
`define ILTU_HALF_DBS 4'h8

// Double-register codes
`define ILTU_DREG_W1 2'h0
`define ILTU_DREG_W2 2'h1
`define ILTU_DREG_SAC 2'h2
`define ILTU_DREG_BASE 2'h3

// Register port offsets
`define ILTU_REG_WORK1 3'h0
`define ILTU_REG_WORK2 3'h1
`define ILTU_REG_COUNTER 3'h2
`define ILTU_REG_BASE 3'h3
`define ILTU_REG_DBS 3'h4
`define ILTU_REG_STATUS 3'h5

// Reset values
`define ILTU_RST_WORK 32'h00000000
`define ILTU_RST_ADDR 20'h00000
`define ILTU_RST_DBS 16'h0000

// System data area word 0 address
`define ILTU_SYS_BASE 20'he1000

// Address steps
`define ILTU_STEP_BYTE 20'h00001
`define ILTU_STEP_WORD 20'h00002

`endif

/* File: design/iltu_core.v */
// Behaviour
// RULE1: half load reads word at work1 address
// RULE2: half codes 0-3 work halves, 8 dbs
// RULE3: half load keeps the other sixteen bits
// RULE4: double load fills chosen 32-bit register; counter and base keep only the low 20 bits
// RULE5: double store writes chosen register to memory
// RULE6: double codes: work1, work2, counter, base
// RULE7: word copy by end addresses, minus 2n
// RULE8: byte copy from work2 end to work1
// RULE9: byte copy reduces both by count
// RULE10: system word load and store
// RULE11: base loads 20-bit immediate
// RULE12: base adds doubled signed offset
// RULE13: relative word load, work1 to work2
// RULE14: relative double load, work1 to work2
// RULE15: relative word store, base unchanged
// RULE16: relative double store, base unchanged
// RULE17: work1 into counter for jump
// RULE18: work1 into base register
// RULE19: counter into work1 or base, top zero
// RULE20: base into work1, top bits zero
// RULE21: base into counter for jump
// RULE22: undefined register codes change nothing
//
// Local design decisions: the strobed register port and the placing of the registers.
`include "iltu_map.vh"

module iltu_core (
	input wire clk,
	input wire rst,
	input wire cmdValid,
	input wire [4:0] cmdOp,
	input wire [19:0] cmdArg,
	output wire cmdReady,
	output reg cmdDone,
	output reg cmdInvalid,
	output reg [19:0] memAddr,
	output reg [15:0] memWrData,
	output reg memRd,
	output reg memWr,
	output reg memByte,
	input wire [15:0] memRdData,
	input wire [2:0] regAddr,
	input wire [31:0] regWrData,
	input wire regWr,
	input wire regRd,
	output reg [31:0] regRdData
);

	localparam S_IDLE = 3'h0;
	localparam S_LDH = 3'h1;
	localparam S_LDL = 3'h2;
	localparam S_LDA = 3'h3;
	localparam S_LDB = 3'h4;
	localparam S_STL = 3'h5;
	localparam S_CPR = 3'h6;
	localparam S_CPW = 3'h7;

	reg [2:0] state_reg, state_next;
	reg [31:0] work1_reg, work1_next;
	reg [31:0] work2_reg, work2_next;
	reg [19:0] counter_reg, counter_next;
	reg [19:0] base_reg, base_next;
	reg [15:0] dbs_reg, dbs_next;
	reg [4:0] op_reg, op_next;
	reg [3:0] sel_reg, sel_next;
	reg [7:0] count_reg, count_next;
	reg [19:0] addr_reg, addr_next;
	reg [15:0] hiWord_reg, hiWord_next;
	reg [31:0] stData_reg, stData_next;
	reg dbl_reg, dbl_next;
	reg [19:0] memAddr_next;
	reg [15:0] memWrData_next;
	reg memRd_next, memWr_next, memByte_next;
	reg cmdDone_next, cmdInvalid_next;

	wire take = cmdValid && (state_reg == S_IDLE);
	assign cmdReady = (state_reg == S_IDLE);

	// Doubled signed word offset, wrapped to 20 bits
	wire [19:0] relOff = {{3{cmdArg[15]}}, cmdArg[15:0], 1'b0}; // RULE12
	wire [19:0] relAddr = base_reg + relOff;
	wire [19:0] copyStep = (op_reg == `ILTU_OP_WORD_COPY) ? `ILTU_STEP_WORD : `ILTU_STEP_BYTE;
	wire halfOk = (cmdArg[3:0] <= `ILTU_HALF_W2_HI) || (cmdArg[3:0] == `ILTU_HALF_DBS);
	wire dregOk = (cmdArg[19:2] == 18'h00000); // RULE22

	// Value of the selected half register
	reg [15:0] halfVal;
	always @* begin
		case (cmdArg[3:0])
			`ILTU_HALF_W1_LO: halfVal = work1_reg[15:0];
			`ILTU_HALF_W1_HI: halfVal = work1_reg[31:16];
			`ILTU_HALF_W2_LO: halfVal = work2_reg[15:0];
			`ILTU_HALF_W2_HI: halfVal = work2_reg[31:16];
			default: halfVal = dbs_reg;
		endcase
	end

	// Value of the selected double register
	reg [31:0] dregVal;
	always @* begin
		case (cmdArg[1:0])
			`ILTU_DREG_W1: dregVal = work1_reg; // RULE6
			`ILTU_DREG_W2: dregVal = work2_reg;
			`ILTU_DREG_SAC: dregVal = {12'h000, counter_reg};
			default: dregVal = {12'h000, base_reg};
		endcase
	end

	always @* begin
		state_next = state_reg;
		work1_next = work1_reg;
		work2_next = work2_reg;
		counter_next = counter_reg;
		base_next = base_reg;
		dbs_next = dbs_reg;
		op_next = op_reg;
		sel_next = sel_reg;
		count_next = count_reg;
		addr_next = addr_reg;
		hiWord_next = hiWord_reg;
		stData_next = stData_reg;
		dbl_next = dbl_reg;
		memAddr_next = memAddr;
		memWrData_next = memWrData;
		memRd_next = 1'b0;
		memWr_next = 1'b0;
		memByte_next = 1'b0;
		cmdDone_next = 1'b0;
		cmdInvalid_next = 1'b0;
		// Software writes only while no instruction runs
		if (regWr && state_reg == S_IDLE) begin
			if (regAddr == `ILTU_REG_WORK1) begin
				work1_next = regWrData;
			end else if (regAddr == `ILTU_REG_WORK2) begin
				work2_next = regWrData;
			end else if (regAddr == `ILTU_REG_COUNTER) begin
				counter_next = regWrData[19:0];
			end else if (regAddr == `ILTU_REG_BASE) begin
				base_next = regWrData[19:0];
			end else if (regAddr == `ILTU_REG_DBS) begin
				dbs_next = regWrData[15:0];
			end
		end
		case (state_reg)
			S_IDLE: begin
				if (take) begin
					op_next = cmdOp;
					sel_next = cmdArg[3:0];
					cmdDone_next = 1'b1;
					case (cmdOp)
						`ILTU_OP_HALF_LOAD: begin
							if (halfOk) begin
								addr_next = work1_reg[19:0]; // RULE1
								dbl_next = 1'b0;
								cmdDone_next = 1'b0;
								state_next = S_LDH;
							end else begin
								cmdInvalid_next = 1'b1; // RULE22
							end
						end
						`ILTU_OP_HALF_STORE: begin
							if (halfOk) begin
								memAddr_next = work1_reg[19:0];
								memWrData_next = halfVal;
								memWr_next = 1'b1;
							end else begin
								cmdInvalid_next = 1'b1; // RULE22
							end
						end
						`ILTU_OP_DBL_LOAD: begin
							if (dregOk) begin
								addr_next = work1_reg[19:0]; // RULE4
								dbl_next = 1'b1;
								cmdDone_next = 1'b0;
								state_next = S_LDH;
							end else begin
								cmdInvalid_next = 1'b1; // RULE22
							end
						end
						`ILTU_OP_DBL_STORE, `ILTU_OP_REL_DSTORE: begin
							if (cmdOp == `ILTU_OP_REL_DSTORE || dregOk) begin
								addr_next = (cmdOp == `ILTU_OP_REL_DSTORE) ? relAddr : work1_reg[19:0]; // RULE5 RULE16
								stData_next = (cmdOp == `ILTU_OP_REL_DSTORE) ? work1_reg : dregVal;
								memAddr_next = (cmdOp == `ILTU_OP_REL_DSTORE) ? relAddr : work1_reg[19:0];
								memWrData_next = (cmdOp == `ILTU_OP_REL_DSTORE) ? work1_reg[31:16] : dregVal[31:16];
								memWr_next = 1'b1;
								cmdDone_next = 1'b0;
								state_next = S_STL;
							end else begin
								cmdInvalid_next = 1'b1; // RULE22
							end
						end
						`ILTU_OP_WORD_COPY, `ILTU_OP_BYTE_COPY: begin
							count_next = cmdArg[7:0]; // RULE7 RULE8
							if (cmdArg[7:0] != 8'h00) begin
								cmdDone_next = 1'b0;
								state_next = S_CPR;
							end
						end
						`ILTU_OP_SYS_LOAD: begin
							addr_next = `ILTU_SYS_BASE + {11'h000, cmdArg[7:0], 1'b0}; // RULE10
							dbl_next = 1'b0;
							cmdDone_next = 1'b0;
							state_next = S_LDH;
						end
						`ILTU_OP_SYS_STORE: begin
							memAddr_next = `ILTU_SYS_BASE + {11'h000, cmdArg[7:0], 1'b0}; // RULE10
							memWrData_next = work1_reg[15:0];
							memWr_next = 1'b1;
						end
						`ILTU_OP_BASE_IMM: base_next = cmdArg; // RULE11
						`ILTU_OP_BASE_ADD: base_next = relAddr; // RULE12
						`ILTU_OP_REL_WLOAD, `ILTU_OP_REL_DLOAD: begin
							addr_next = relAddr; // RULE13 RULE14
							dbl_next = (cmdOp == `ILTU_OP_REL_DLOAD);
							cmdDone_next = 1'b0;
							state_next = S_LDH;
						end
						`ILTU_OP_REL_WSTORE: begin
							memAddr_next = relAddr; // RULE15
							memWrData_next = work1_reg[15:0];
							memWr_next = 1'b1;
						end
						`ILTU_OP_JUMP_WORK: counter_next = work1_reg[19:0]; // RULE17
						`ILTU_OP_WORK_TO_BASE: base_next = work1_reg[19:0]; // RULE18
						`ILTU_OP_CNT_TO_WORK: work1_next = {12'h000, counter_reg}; // RULE19
						`ILTU_OP_CNT_TO_BASE: base_next = counter_reg; // RULE19
						`ILTU_OP_BASE_TO_WORK: work1_next = {12'h000, base_reg}; // RULE20
						`ILTU_OP_BASE_TO_CNT: counter_next = base_reg; // RULE21
						default: cmdInvalid_next = 1'b1; // RULE22
					endcase
				end
			end
			S_LDH: begin
				memAddr_next = addr_reg;
				memRd_next = 1'b1;
				state_next = S_LDL;
			end
			S_LDL: begin
				if (dbl_reg) begin
					memAddr_next = addr_reg + `ILTU_STEP_WORD;
					memRd_next = 1'b1;
				end
				state_next = S_LDA;
			end
			S_LDA: begin
				hiWord_next = memRdData;
				if (dbl_reg) begin
					state_next = S_LDB;
				end else begin
					state_next = S_IDLE;
					cmdDone_next = 1'b1;
					case (op_reg)
						`ILTU_OP_HALF_LOAD: begin
							case (sel_reg)
								`ILTU_HALF_W1_LO: work1_next = {work1_reg[31:16], memRdData}; // RULE2 RULE3
								`ILTU_HALF_W1_HI: work1_next = {memRdData, work1_reg[15:0]}; // RULE3
								`ILTU_HALF_W2_LO: work2_next = {work2_reg[31:16], memRdData}; // RULE3
								`ILTU_HALF_W2_HI: work2_next = {memRdData, work2_reg[15:0]}; // RULE3
								default: dbs_next = memRdData; // RULE2
							endcase
						end
						`ILTU_OP_REL_WLOAD: begin
							work2_next = work1_reg; // RULE13
							work1_next = {work1_reg[31:16], memRdData};
						end
						default: work1_next = {work1_reg[31:16], memRdData}; // RULE10
					endcase
				end
			end
			S_LDB: begin
				state_next = S_IDLE;
				cmdDone_next = 1'b1;
				if (op_reg == `ILTU_OP_REL_DLOAD) begin
					work2_next = work1_reg; // RULE14
					work1_next = {hiWord_reg, memRdData};
				end else begin
					case (sel_reg[1:0])
						`ILTU_DREG_W1: work1_next = {hiWord_reg, memRdData}; // RULE4 RULE6
						`ILTU_DREG_W2: work2_next = {hiWord_reg, memRdData};
						`ILTU_DREG_SAC: counter_next = {hiWord_reg[3:0], memRdData};
						default: base_next = {hiWord_reg[3:0], memRdData};
					endcase
				end
			end
			S_STL: begin
				memAddr_next = addr_reg + `ILTU_STEP_WORD; // RULE5
				memWrData_next = stData_reg[15:0];
				memWr_next = 1'b1;
				cmdDone_next = 1'b1;
				state_next = S_IDLE;
			end
			S_CPR: begin
				memAddr_next = work2_reg[19:0]; // RULE8
				memByte_next = !memRd && (op_reg == `ILTU_OP_BYTE_COPY);
				memRd_next = !memRd;
				if (memRd) begin
					state_next = S_CPW;
				end
			end
			S_CPW: begin
				// Read data of the source element is on memRdData now
				memAddr_next = work1_reg[19:0];
				memWrData_next = (op_reg == `ILTU_OP_BYTE_COPY) ? {8'h00, memRdData[7:0]} : memRdData;
				memByte_next = (op_reg == `ILTU_OP_BYTE_COPY);
				memWr_next = 1'b1;
				work1_next = work1_reg - {12'h000, copyStep}; // RULE7 RULE9
				work2_next = work2_reg - {12'h000, copyStep}; // RULE7 RULE9
				count_next = count_reg - 8'h01;
				if (count_reg == 8'h01) begin
					cmdDone_next = 1'b1;
					state_next = S_IDLE;
				end else begin
					state_next = S_CPR;
				end
			end
			default: state_next = S_IDLE;
		endcase
	end

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			state_reg <= S_IDLE;
			work1_reg <= `ILTU_RST_WORK;
			work2_reg <= `ILTU_RST_WORK;
			counter_reg <= `ILTU_RST_ADDR;
			base_reg <= `ILTU_RST_ADDR;
			dbs_reg <= `ILTU_RST_DBS;
			op_reg <= 5'h00;
			sel_reg <= 4'h0;
			count_reg <= 8'h00;
			addr_reg <= `ILTU_RST_ADDR;
			hiWord_reg <= 16'h0000;
			stData_reg <= 32'h00000000;
			dbl_reg <= 1'b0;
			memAddr <= `ILTU_RST_ADDR;
			memWrData <= 16'h0000;
			memRd <= 1'b0;
			memWr <= 1'b0;
			memByte <= 1'b0;
			cmdDone <= 1'b0;
			cmdInvalid <= 1'b0;
		end else begin
			state_reg <= state_next;
			work1_reg <= work1_next;
			work2_reg <= work2_next;
			counter_reg <= counter_next;
			base_reg <= base_next;
			dbs_reg <= dbs_next;
			op_reg <= op_next;
			sel_reg <= sel_next;
			count_reg <= count_next;
			addr_reg <= addr_next;
			hiWord_reg <= hiWord_next;
			stData_reg <= stData_next;
			dbl_reg <= dbl_next;
			memAddr <= memAddr_next;
			memWrData <= memWrData_next;
			memRd <= memRd_next;
			memWr <= memWr_next;
			memByte <= memByte_next;
			cmdDone <= cmdDone_next && !cmdInvalid_next; // RULE22
			cmdInvalid <= cmdInvalid_next;
		end
	end

	// Register read port, data one cycle after the strobe
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			regRdData <= 32'h00000000;
		end else if (regRd) begin
			if (regAddr == `ILTU_REG_WORK1) begin
				regRdData <= work1_reg;
			end else if (regAddr == `ILTU_REG_WORK2) begin
				regRdData <= work2_reg;
			end else if (regAddr == `ILTU_REG_COUNTER) begin
				regRdData <= {12'h000, counter_reg};
			end else if (regAddr == `ILTU_REG_BASE) begin
				regRdData <= {12'h000, base_reg};
			end else if (regAddr == `ILTU_REG_DBS) begin
				regRdData <= {16'h0000, dbs_reg};
			end else if (regAddr == `ILTU_REG_STATUS) begin
				regRdData <= {24'h000000, count_reg};
				regRdData[31] <= (state_reg != S_IDLE);
			end else begin
				regRdData <= 32'h00000000;
			end
		end else begin
			regRdData <= 32'h00000000;
		end
	end

endmodule // iltu_core

/* File: verification/iltu_mem_model.sv */
module iltu_mem_model (
	input wire clk,
	input wire [19:0] memAddr,
	input wire [15:0] memWrData,
	input wire memRd,
	input wire memWr,
	input wire memByte,
	output logic [15:0] memRdData
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] mem [int];
	// Unwritten bytes read back as an address pattern, the inverted low address byte
	function automatic logic [7:0] at(input int a);
		return mem.exists(a) ? mem[a] : ~a[7:0];
	endfunction
	initial memRdData = 16'h0;
	// Words are big-endian: high byte at the even address
	always @(posedge clk) begin
		if (memWr && memByte)
			mem[memAddr] = memWrData[7:0];
		else if (memWr) begin
			mem[memAddr] = memWrData[15:8];
			mem[memAddr + 20'h1] = memWrData[7:0];
		end
		// Read data stand one cycle only, then the bus toggles
		if (memRd)
			memRdData <= memByte ? {~at(memAddr), at(memAddr)} : {at(memAddr), at(memAddr + 20'h1)};
		else
			memRdData <= ~memRdData;
	end
endmodule // iltu_mem_model

/* File: verification/iltu_core_sva.sv */
`include "iltu_map.vh"
module iltu_sva (
	input wire clk,
	input wire rst,
	input wire cmdValid,
	input wire [4:0] cmdOp,
	input wire [19:0] cmdArg,
	input wire cmdReady,
	input wire cmdDone,
	input wire cmdInvalid,
	input wire [19:0] memAddr,
	input wire memRd,
	input wire memWr,
	input wire memByte
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	wire take = cmdValid && cmdReady;
	logic [19:0] sysAddr;
	always @(posedge clk) sysAddr <= `ILTU_SYS_BASE + {11'h0, cmdArg[7:0], 1'b0};
	sequence sHalfLoad;
		take && cmdOp == `ILTU_OP_HALF_LOAD && cmdArg[3:2] == 2'b00 && cmdArg[19:4] == 16'h0;
	endsequence
	sequence sFetchDone;
		memRd && !memByte ##2 cmdDone;
	endsequence
	sequence sPairWrite;
		memWr && !cmdDone ##1 memWr && cmdDone;
	endsequence
	chk_half_fetch: assert property (sHalfLoad |-> ##2 sFetchDone) else $error("half load timing wrong");
	chk_busy_hold: assert property (sHalfLoad |=> !cmdReady [*3] ##1 cmdReady) else $error("busy span wrong");
	chk_dstore_pair: assert property (take && cmdOp == `ILTU_OP_DBL_STORE && cmdArg[19:2] == 18'h0
		|=> sPairWrite) else $error("double store not two writes");
	chk_pair_addr: assert property (memWr && $past(memWr) && !$past(cmdDone)
		|-> memAddr == $past(memAddr) + 20'h00002) else $error("second word address wrong");
	chk_sys_addr: assert property (take && cmdOp == `ILTU_OP_SYS_STORE
		|=> memWr && cmdDone && memAddr == sysAddr) else $error("system word address wrong");
	chk_base_only: assert property (take && (cmdOp == `ILTU_OP_BASE_IMM || cmdOp == `ILTU_OP_BASE_ADD)
		|=> cmdDone && !memRd && !memWr) else $error("base op touched memory");
	chk_bad_half: assert property (take && cmdOp == `ILTU_OP_HALF_LOAD && cmdArg[3:2] == 2'b01
		|=> cmdInvalid && !cmdDone && !memRd && !memWr) else $error("bad half code accepted");
	chk_empty_copy: assert property (take && (cmdOp == `ILTU_OP_BYTE_COPY || cmdOp == `ILTU_OP_WORD_COPY)
		&& cmdArg[7:0] == 8'h00 |=> cmdDone && !memWr) else $error("empty copy wrote");
	chk_end_excl: assert property (!(cmdDone && cmdInvalid)) else $error("done and invalid together");
endmodule // iltu_sva
bind iltu_core iltu_sva iltu_sva_i (.clk(clk), .rst(rst), .cmdValid(cmdValid), .cmdOp(cmdOp), .cmdArg(cmdArg),
	.cmdReady(cmdReady), .cmdDone(cmdDone), .cmdInvalid(cmdInvalid), .memAddr(memAddr), .memRd(memRd),
	.memWr(memWr), .memByte(memByte));

/* File: verification/test_iltu_core.sv */
`include "iltu_map.vh"
`define CHK(g, e) begin nChecks++; if ((g) !== (e)) begin failCount++; $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module test_iltu_core;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 0, rst = 1, cmdValid = 0, regWr = 0, regRd = 0, seen = 0;
	logic [4:0] cmdOp = 0;
	logic [19:0] cmdArg = 0;
	logic [2:0] regAddr = 0;
	logic [31:0] regWrData = 0, regRdData, w1, w2, x, er;
	logic [31:0] v [4];
	wire cmdReady, cmdDone, cmdInvalid, memRd, memWr, memByte;
	wire [19:0] memAddr;
	wire [15:0] memWrData, memRdData;
	int failCount = 0, nChecks = 0, a, s, n, sz;
	int hc [6] = '{0, 1, 2, 3, 8, 5};
	logic [31:0] qr [$];
	logic qc [$];
	logic ei;
	iltu_core iltu_core_i (.clk(clk), .rst(rst), .cmdValid(cmdValid), .cmdOp(cmdOp), .cmdArg(cmdArg),
		.cmdReady(cmdReady), .cmdDone(cmdDone), .cmdInvalid(cmdInvalid), .memAddr(memAddr), .memWrData(memWrData),
		.memRd(memRd), .memWr(memWr), .memByte(memByte), .memRdData(memRdData), .regAddr(regAddr),
		.regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData));
	iltu_mem_model iltu_mem_model_i (.clk(clk), .memAddr(memAddr), .memWrData(memWrData), .memRd(memRd),
		.memWr(memWr), .memByte(memByte), .memRdData(memRdData));
	always #5 clk = ~clk;
	// Result watcher: read data and instruction endings against the oldest note
	always @(posedge clk) begin
		if (seen) begin
			er = qr.pop_front();
			`CHK(regRdData, er)
		end
		if (cmdDone || cmdInvalid) begin
			ei = qc.pop_front();
			`CHK(cmdInvalid, ei)
		end
		seen <= regRd;
	end
	task automatic wr(input logic [2:0] ad, input logic [31:0] d);
		@(posedge clk);
		regWr <= 1;
		regAddr <= ad;
		regWrData <= d;
		@(posedge clk);
		regWr <= 0;
	endtask
	task automatic rd(input logic [2:0] ad, input logic [31:0] e);
		@(posedge clk);
		regRd <= 1;
		regAddr <= ad;
		qr.push_back(e);
		@(posedge clk);
		regRd <= 0;
	endtask
	task automatic op(input logic [4:0] o, input logic [19:0] g, input logic bad);
		int i;
		@(posedge clk);
		cmdValid <= 1;
		cmdOp <= o;
		cmdArg <= g;
		qc.push_back(bad);
		do @(posedge clk); while (!cmdReady);
		cmdValid <= 0;
		i = 0;
		do begin
			@(posedge clk);
			i++;
		end while (!(cmdDone || cmdInvalid) && i < 3000);
		if (i == 3000)
			failCount++;
		// Let the memory model take the last write before anyone looks
		@(posedge clk);
	endtask
	task automatic pw(input int ad, input logic [15:0] d);
		iltu_mem_model_i.mem[ad] = d[15:8];
		iltu_mem_model_i.mem[ad + 1] = d[7:0];
	endtask
	function automatic logic [15:0] mw(input int ad);
		return {iltu_mem_model_i.at(ad), iltu_mem_model_i.at(ad + 1)};
	endfunction
	task automatic giveVerdict;
		$display("checks %0d mismatches %0d", nChecks, failCount);
		if (failCount == 0 && nChecks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial begin
		#200us;
		failCount++;
		giveVerdict();
	end
	initial begin
		x = $urandom(46451);
		repeat (16) @(posedge clk);
		rst <= 0;
		for (a = 0; a < 8; a++)
			rd(a[2:0], 32'h0);
		$display("reset values done");
		for (a = 0; a < 6; a++) begin
			w1 = $urandom & 32'hfffffffe;
			w2 = $urandom;
			x = $urandom;
			pw(w1[19:0], x[15:0]);
			wr(0, w1);
			wr(1, w2);
			wr(4, 32'h0);
			op(`ILTU_OP_HALF_LOAD, hc[a], hc[a] == 5);
			case (hc[a])
				0: w1[15:0] = x[15:0];
				1: w1[31:16] = x[15:0];
				2: w2[15:0] = x[15:0];
				3: w2[31:16] = x[15:0];
				default: ;
			endcase
			rd(0, w1);
			rd(1, w2);
			rd(4, {16'h0, (hc[a] == 8) ? x[15:0] : 16'h0});
			case (hc[a])
				0: x[31:16] = w1[15:0];
				1: x[31:16] = w1[31:16];
				2: x[31:16] = w2[15:0];
				3: x[31:16] = w2[31:16];
				8: x[31:16] = x[15:0];
				default: x[31:16] = mw(w1[19:0]);
			endcase
			op(`ILTU_OP_HALF_STORE, hc[a], hc[a] == 5);
			`CHK(mw(w1[19:0]), x[31:16])
		end
		$display("half load done");
		for (a = 0; a < 4; a++) begin
			v = '{$urandom & 32'h000ffffc, $urandom, $urandom & 32'h000fffff, $urandom & 32'h000fffff};
			x = $urandom;
			for (s = 0; s < 4; s++)
				wr(s[2:0], v[s]);
			op(`ILTU_OP_DBL_STORE, a, 0);
			`CHK({mw(v[0][19:0]), mw(v[0][19:0] + 2)}, v[a])
			pw(v[0][19:0], x[31:16]);
			pw(v[0][19:0] + 2, x[15:0]);
			op(`ILTU_OP_DBL_LOAD, a, 0);
			rd(a[2:0], a < 2 ? x : x & 32'h000fffff);
		end
		op(`ILTU_OP_DBL_LOAD, 20'h00004, 1);
		op(5'h1f, 20'h0, 1);
		rd(0, v[0]);
		$display("double access done");
		for (a = 0; a < 3; a++) begin
			n = (a == 0) ? 255 : (a == 1) ? 7 : 0;
			sz = (a == 1) ? 2 : 1;
			w1 = 32'h00030ffe;
			w2 = 32'h00050ffe;
			for (s = 0; s < n; s++) begin
				x = $urandom;
				pw(w2[19:0] - sz * s, x[15:0]);
			end
			wr(0, w1);
			wr(1, w2);
			op(a == 1 ? `ILTU_OP_WORD_COPY : `ILTU_OP_BYTE_COPY, n, 0);
			for (s = 0; s < n; s++)
				`CHK({iltu_mem_model_i.at(w1[19:0] - sz * s), iltu_mem_model_i.at(w1[19:0] - sz * s + sz - 1)},
					{iltu_mem_model_i.at(w2[19:0] - sz * s), iltu_mem_model_i.at(w2[19:0] - sz * s + sz - 1)})
			rd(0, w1 - n * sz);
			rd(1, w2 - n * sz);
		end
		$display("block copy done");
		s = $urandom_range(255);
		w1 = $urandom;
		wr(0, w1);
		op(`ILTU_OP_SYS_STORE, s, 0);
		`CHK(mw(32'he1000 + 2 * s), w1[15:0])
		pw(32'he1000 + 2 * s, ~w1[15:0]);
		op(`ILTU_OP_SYS_LOAD, s, 0);
		rd(0, {w1[31:16], ~w1[15:0]});
		$display("system data done");
		op(`ILTU_OP_BASE_IMM, 20'hfffff, 0);
		rd(3, 32'h000fffff);
		op(`ILTU_OP_BASE_ADD, 20'h0ffff, 0);
		rd(3, 32'h000ffffd);
		op(`ILTU_OP_BASE_IMM, 20'h40000, 0);
		w1 = $urandom;
		w2 = $urandom;
		wr(0, w1);
		op(`ILTU_OP_REL_WSTORE, 20'h08000, 0);
		`CHK(mw(32'h30000), w1[15:0])
		op(`ILTU_OP_REL_DSTORE, 20'h07fff, 0);
		`CHK({mw(32'h4fffe), mw(32'h50000)}, w1)
		pw(32'h30000, w2[15:0]);
		op(`ILTU_OP_REL_WLOAD, 20'h08000, 0);
		rd(0, {w1[31:16], w2[15:0]});
		rd(1, w1);
		pw(32'h4fffe, w2[31:16]);
		pw(32'h50000, w2[15:0]);
		op(`ILTU_OP_REL_DLOAD, 20'h07fff, 0);
		rd(0, w2);
		rd(1, {w1[31:16], w2[15:0]});
		rd(3, 32'h00040000);
		$display("base relative done");
		wr(0, 32'h000abcde);
		op(`ILTU_OP_JUMP_WORK, 20'h0, 0);
		rd(2, 32'h000abcde);
		wr(0, 32'h00012346);
		op(`ILTU_OP_WORK_TO_BASE, 20'h0, 0);
		rd(3, 32'h00012346);
		wr(0, 32'hffffffff);
		op(`ILTU_OP_CNT_TO_WORK, 20'h0, 0);
		rd(0, 32'h000abcde);
		op(`ILTU_OP_CNT_TO_BASE, 20'h0, 0);
		rd(3, 32'h000abcde);
		wr(3, 32'h00055554);
		wr(0, 32'hffffffff);
		op(`ILTU_OP_BASE_TO_WORK, 20'h0, 0);
		rd(0, 32'h00055554);
		op(`ILTU_OP_BASE_TO_CNT, 20'h0, 0);
		rd(2, 32'h00055554);
		$display("register moves done");
		repeat (3) @(posedge clk);
		giveVerdict();
	end
endmodule // test_iltu_core
